//--- sdd_defs.vh
// Constants for the sigma-delta decimation control block.
`ifndef SDD_DEFS_VH
`define SDD_DEFS_VH
`define SDD_ADDR_DECIM 8'hd4
`define SDD_ADDR_MODE 8'hd1
`define SDD_ADDR_STATUS 8'hd8
`define SDD_ADDR_CTRL 8'hd2
`define SDD_DECIM_RESET 8'h45
`define SDD_DECIM_MIN_OFF 8'h03
`define SDD_DECIM_MIN_ON 8'h0d
`define SDD_MODE_RESET 8'h00
`define SDD_CTRL_RESET 8'h00
`define SDD_MODE_CHOP_DIS 3
`define SDD_MODE_NOTCH 6
`define SDD_CTRL_REFSEL_MAIN 0
`define SDD_CTRL_REFSEL_AUX 1
`define SDD_CTRL_BUF_LO 2
`define SDD_CTRL_BUF_HI 3
`define SDD_CTRL_BURNOUT 4
`define SDD_CTRL_CAL_OFS 5
`define SDD_CTRL_CAL_GAIN 6
`define SDD_STAT_NOREF 4
`define SDD_STAT_ERR_MAIN 3
`define SDD_STAT_ERR_AUX 2
`define SDD_STAT_RDY 7
`define SDD_STAT_CAL 6
`define SDD_OSR 8
`define SDD_CHOP_MULT 3
`define SDD_SETTLE_CONV 3
`define SDD_NOTCH_LEN 546
`endif

//--- sdd_sinc3.v
// Third-order sinc decimator for a 1-bit modulator stream.
`timescale 1ns/1ps
module sdd_sinc3 #(
  parameter W = 36
) (
  input wire clk, // System clock.
  input wire sys_rst, // Synchronous reset, active high.
  input wire bit_in, // Modulator bit, synchronised.
  input wire sample_en, // One pulse per modulator sample.
  input wire dump, // Decimation boundary, coincides with sample_en.
  output reg [W-1:0] result // Filtered output, updated on dump.
);
  reg [W-1:0] i1, i2, i3, d1, d2, d3;
  wire [W-1:0] c1 = i3 - d1;
  wire [W-1:0] c2 = c1 - d2;
  wire [W-1:0] c3 = c2 - d3;
  // Integrators run each sample; combs run at the decimated rate.
  always @(posedge clk) begin
    if (sys_rst) begin
      i1 <= {W{1'b0}};
      i2 <= {W{1'b0}};
      i3 <= {W{1'b0}};
      d1 <= {W{1'b0}};
      d2 <= {W{1'b0}};
      d3 <= {W{1'b0}};
      result <= {W{1'b0}};
    end else if (sample_en) begin
      i1 <= i1 + {{(W-1){1'b0}}, bit_in};
      i2 <= i2 + i1;
      i3 <= i3 + i2;
      if (dump) begin
        d1 <= i3;
        d2 <= c1;
        d3 <= c2;
        result <= c3;
      end
    end
  end
endmodule

//--- sdd_core.v
// Decimation control, reference detect and registers of the sigma-delta back end.
// Summary of operation
// - Decimation word register sets the sinc3 decimation factor and output rate.
// - Rate is modulator rate over 8 times word, times 3 more with chop.
// - Chop off: word must be 3 to 255; software keeps it there.
// - Chop on: words below 13 act as 13; maximum is 255.
// - Chop-disable mode bit: 0 enables chopping, 1 disables it.
// - Mode bit 6 adds a fixed 60 Hz notch to the filter.
// - Each converter picks internal or external reference by its select bit.
// - Missing reference sets flag, clamps results, blocks calibration updates.
// - Reference loss during calibration keeps register and sets its error flag.
// - Reference detect watches only the primary reference pin pair.
// - Calibration uses the same word as conversion: the word latched at the last chop-phase boundary, not the current software word.
// - Burnout sources usable only while input buffering is enabled.
// - Filter takes the 1-bit modulator output and makes multi-bit words.
// - Decimation word resets to 69.
// - Chop off: two results withheld after a step or channel change; the third is output.
`timescale 1ns/1ps
`include "sdd_defs.vh"
module sdd_core #(
  parameter MOD_DIV = 3052, // System cycles per modulator sample.
  parameter RES_W = 24, // Result width.
  parameter CAL_W = 24 // Calibration register width.
) (
  input wire clk, // 100 MHz system clock.
  input wire sys_rst, // Synchronous reset, active high.
  input wire [7:0] sfr_addr, // Register address.
  input wire [7:0] sfr_wdata, // Register write data.
  input wire sfr_wr, // Register write strobe.
  input wire sfr_rd, // Register read strobe.
  output reg [7:0] sfr_rdata, // Register read data.
  input wire mod_bit, // Modulator comparator bit, asynchronous.
  input wire ref_pos_ok, // Primary positive reference pin valid, asynchronous.
  input wire ref_neg_ok, // Primary negative reference pin valid, asynchronous.
  input wire ref2_ok, // Secondary reference pair valid, not monitored.
  input wire step_change, // Channel or synchronized step change pulse.
  output reg [RES_W-1:0] conv_data, // Conversion result.
  output reg conv_valid, // One-cycle pulse with a new result.
  output reg [CAL_W-1:0] cal_offset, // Offset calibration register.
  output reg [CAL_W-1:0] cal_gain, // Gain calibration register.
  output wire main_use_ext_ref, // Main converter uses external reference.
  output wire aux_use_ext_ref, // Auxiliary converter uses external reference.
  output wire burnout_en, // Burnout current sources enabled.
  output wire [1:0] input_buffer_select // Input buffer control.
);
  localparam ST_RUN = 2'd0;
  localparam ST_OFS = 2'd1;
  localparam ST_GAIN = 2'd2;
  localparam FW = 36;
  localparam [1:0] SETTLE_LOAD = `SDD_SETTLE_CONV - 1; // Skipped results after a step.
  reg [7:0] decimation_factor;
  reg [7:0] converter_mode_register;
  reg [7:0] ctrl;
  reg missing_reference_flag, main_cal_error_flag, aux_cal_error_flag, data_ready;
  reg [1:0] state;
  reg cal_aborted;
  reg [1:0] settle_cnt;
  reg [1:0] chop_phase;
  reg [7:0] active_word;
  reg [11:0] mod_cnt;
  reg [10:0] dec_cnt;
  reg [9:0] notch_cnt;
  reg [FW-1:0] notch_acc;
  reg mb_s1, mb_s2, rp_s1, rp_s2, rn_s1, rn_s2;
  wire sample_en = (mod_cnt == MOD_DIV - 1);
  wire chop_dis = converter_mode_register[`SDD_MODE_CHOP_DIS];
  wire notch_on = converter_mode_register[`SDD_MODE_NOTCH];
  wire ref_bad = ~(rp_s2 & rn_s2);
  wire [FW-1:0] sinc_out;
  // Chop on clamps short words to 13; chop off uses the word as written.
  wire [7:0] eff_word = (!chop_dis && decimation_factor < `SDD_DECIM_MIN_ON) ?
                        `SDD_DECIM_MIN_ON : decimation_factor;
  // One decimation period is eight modulator samples per unit of the latched word.
  wire [10:0] dec_len = {active_word, 3'b000};
  wire dump = sample_en && (dec_cnt == dec_len - 11'h001);
  wire last_phase = chop_dis || (chop_phase == `SDD_CHOP_MULT - 1);
  wire [FW-1:0] notch_out = notch_acc;
  wire [FW-1:0] filt = notch_on ? ((sinc_out >> 1) + (notch_out >> 1)) : sinc_out;
  wire [RES_W-1:0] scaled = filt[FW-1 -: RES_W];
  assign main_use_ext_ref = ctrl[`SDD_CTRL_REFSEL_MAIN];
  assign aux_use_ext_ref = ctrl[`SDD_CTRL_REFSEL_AUX];
  assign input_buffer_select = ctrl[`SDD_CTRL_BUF_HI:`SDD_CTRL_BUF_LO];
  assign burnout_en = ctrl[`SDD_CTRL_BURNOUT] && (input_buffer_select != 2'b00);

  // Pin inputs pass two flip-flops before use.
  always @(posedge clk) begin
    if (sys_rst) begin
      mb_s1 <= 1'b0;
      mb_s2 <= 1'b0;
      rp_s1 <= 1'b0;
      rp_s2 <= 1'b0;
      rn_s1 <= 1'b0;
      rn_s2 <= 1'b0;
    end else begin
      mb_s1 <= mod_bit;
      mb_s2 <= mb_s1;
      rp_s1 <= ref_pos_ok;
      rp_s2 <= rp_s1;
      rn_s1 <= ref_neg_ok;
      rn_s2 <= rn_s1;
    end
  end

  // The sinc3 decimator turns the modulator bits into multi-bit words.
  sdd_sinc3 #(.W(FW)) u_sinc (
    .clk(clk),
    .sys_rst(sys_rst),
    .bit_in(mb_s2),
    .sample_en(sample_en),
    .dump(dump),
    .result(sinc_out)
  );

  // Modulator-rate divider and decimation counters; word latched on each last-chop-phase boundary.
  always @(posedge clk) begin
    if (sys_rst) begin
      mod_cnt <= 12'h000;
      dec_cnt <= 11'h000;
      chop_phase <= 2'b00;
      active_word <= `SDD_DECIM_RESET;
    end else begin
      mod_cnt <= sample_en ? 12'h000 : mod_cnt + 12'h001;
      if (sample_en) begin
        if (dump) begin
          dec_cnt <= 11'h000;
          chop_phase <= last_phase ? 2'b00 : chop_phase + 2'b01;
          if (last_phase)
            active_word <= eff_word;
        end else begin
          dec_cnt <= dec_cnt + 11'h001;
        end
      end
    end
  end

  // Block sum over one 60 Hz period, restarted each period, approximates the added line notch.
  always @(posedge clk) begin
    if (sys_rst) begin
      notch_cnt <= 10'h000;
      notch_acc <= {FW{1'b0}};
    end else if (sample_en && notch_on) begin
      if (notch_cnt == `SDD_NOTCH_LEN - 1) begin
        notch_cnt <= 10'h000;
        notch_acc <= {{(FW-1){1'b0}}, mb_s2};
      end else begin
        notch_cnt <= notch_cnt + 10'h001;
        notch_acc <= notch_acc + {{(FW-1){1'b0}}, mb_s2};
      end
    end
  end

  // Result output, settling suppression, clamping and calibration capture.
  always @(posedge clk) begin
    if (sys_rst) begin
      conv_data <= {RES_W{1'b0}};
      conv_valid <= 1'b0;
      settle_cnt <= 2'b00;
      cal_offset <= {CAL_W{1'b0}};
      cal_gain <= {CAL_W{1'b0}};
      state <= ST_RUN;
      cal_aborted <= 1'b0;
      data_ready <= 1'b0;
      missing_reference_flag <= 1'b0;
      main_cal_error_flag <= 1'b0;
      aux_cal_error_flag <= 1'b0;
    end else begin
      conv_valid <= 1'b0;
      missing_reference_flag <= ref_bad;
      if (sfr_rd && sfr_addr == `SDD_ADDR_STATUS) begin
        data_ready <= 1'b0;
        main_cal_error_flag <= 1'b0;
        aux_cal_error_flag <= 1'b0;
      end
      if (step_change && chop_dis)
        settle_cnt <= SETTLE_LOAD;
      else if (sample_en && dump && last_phase) begin
        if (settle_cnt != 2'b00) begin
          settle_cnt <= settle_cnt - 2'b01;
        end else if (state == ST_RUN) begin
          conv_data <= ref_bad ? {RES_W{1'b1}} : scaled;
          conv_valid <= 1'b1;
          data_ready <= 1'b1;
        end
      end
      if (state != ST_RUN && ref_bad)
        cal_aborted <= 1'b1;
      // Calibration uses the running word; it completes on the next last-chop-phase boundary.
      if (state == ST_RUN && sfr_wr && sfr_addr == `SDD_ADDR_CTRL) begin
        cal_aborted <= 1'b0;
        if (sfr_wdata[`SDD_CTRL_CAL_OFS])
          state <= ST_OFS;
        else if (sfr_wdata[`SDD_CTRL_CAL_GAIN])
          state <= ST_GAIN;
      end else if (state != ST_RUN && sample_en && dump && last_phase) begin
        state <= ST_RUN;
        if (cal_aborted || ref_bad) begin
          if (state == ST_OFS)
            main_cal_error_flag <= 1'b1;
          else
            aux_cal_error_flag <= 1'b1;
        end else if (state == ST_OFS)
          cal_offset <= scaled;
        else
          cal_gain <= scaled;
      end
    end
  end

  // Register writes; the decimation word resets to 69.
  always @(posedge clk) begin
    if (sys_rst) begin
      decimation_factor <= `SDD_DECIM_RESET;
      converter_mode_register <= `SDD_MODE_RESET;
      ctrl <= `SDD_CTRL_RESET;
    end else if (sfr_wr) begin
      if (sfr_addr == `SDD_ADDR_DECIM)
        decimation_factor <= sfr_wdata;
      else if (sfr_addr == `SDD_ADDR_MODE)
        converter_mode_register <= sfr_wdata;
      else if (sfr_addr == `SDD_ADDR_CTRL)
        ctrl <= {1'b0, 2'b00, sfr_wdata[4:0]};
    end
  end

  // Read data, registered; unmapped addresses read zero.
  always @(posedge clk) begin
    if (sys_rst)
      sfr_rdata <= 8'h00;
    else if (sfr_rd) begin
      if (sfr_addr == `SDD_ADDR_DECIM)
        sfr_rdata <= decimation_factor;
      else if (sfr_addr == `SDD_ADDR_MODE)
        sfr_rdata <= converter_mode_register;
      else if (sfr_addr == `SDD_ADDR_CTRL)
        sfr_rdata <= ctrl;
      else if (sfr_addr == `SDD_ADDR_STATUS)
        sfr_rdata <= {data_ready, state != ST_RUN, 1'b0, missing_reference_flag,
                      main_cal_error_flag, aux_cal_error_flag, 2'b00};
      else
        sfr_rdata <= 8'h00;
    end
  end
endmodule

//--- sdd_mod_model.sv
// Modulator stand-in that turns a fixed input level into a 1-bit stream.
`timescale 1ns/1ps
module sdd_mod_model #(
  parameter DIV = 4
) (
  input wire logic clk, // Clock.
  input wire logic [7:0] level, // Input level, 0 to 255.
  output logic mod_bit // Comparator output bit.
);
  logic [8:0] acc = 9'h000;
  int tick = 0;
  // First-order loop: the carry of the accumulator is the comparator output.
  always @(posedge clk) begin
    tick <= (tick == DIV - 1) ? 0 : tick + 1;
    if (tick == 0) begin
      acc <= {1'b0, acc[7:0]} + {1'b0, level};
    end
  end
  assign mod_bit = acc[8];
endmodule

//--- sdd_core_properties.sv
// Concurrent checks on the ports of the decimation control core.
`timescale 1ns/1ps
module sdd_core_chk #(
  parameter MOD_DIV = 3052,
  parameter RES_W = 24,
  parameter CAL_W = 24
) (
  input wire logic clk, // Clock.
  input wire logic sys_rst, // Reset, active high.
  input wire logic sfr_wr, // Write strobe.
  input wire logic sfr_rd, // Read strobe.
  input wire logic ref_pos_ok, // Primary positive reference valid.
  input wire logic ref_neg_ok, // Primary negative reference valid.
  input wire logic step_change, // Step or channel change.
  input wire logic [7:0] sfr_addr, // Register address.
  input wire logic [7:0] sfr_wdata, // Register write data.
  input wire logic [7:0] sfr_rdata, // Register read data.
  input wire logic conv_valid, // Result strobe.
  input wire logic main_use_ext_ref, // Main reference select.
  input wire logic aux_use_ext_ref, // Auxiliary reference select.
  input wire logic burnout_en, // Burnout enable.
  input wire logic [1:0] input_buffer_select, // Buffer control.
  input wire logic [RES_W-1:0] conv_data, // Result.
  input wire logic [CAL_W-1:0] cal_offset, // Offset calibration value.
  input wire logic [CAL_W-1:0] cal_gain // Gain calibration value.
);
  logic [7:0] word, mode, eff;
  logic [4:0] ctl_lo;
  logic [1:0] clean;
  int gap, period;
  // Expected pin image of a control write and the expected result spacing.
  assign ctl_lo = {sfr_wdata[4] & (|sfr_wdata[3:2]), sfr_wdata[3:0]};
  assign eff = (!mode[3] && word < 8'h0d) ? 8'h0d : word;
  assign period = MOD_DIV * 8 * eff * (mode[3] ? 1 : 3);
  // Shadow of the rate settings; spacing is only judged two results after any change.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      word <= 8'h45;
      mode <= 8'h00;
      gap <= 0;
      clean <= 2'h0;
    end else begin
      if (sfr_wr && sfr_addr == 8'hd4) word <= sfr_wdata;
      if (sfr_wr && sfr_addr == 8'hd1) mode <= sfr_wdata;
      gap <= conv_valid ? 1 : gap + 1;
      if (sfr_wr || step_change) clean <= 2'h0;
      else if (conv_valid && clean != 2'h2) clean <= clean + 2'h1;
    end
  end
  AST_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
    conv_valid |=> !conv_valid) else $error("result strobe longer than one cycle");
  AST_PERIOD: assert property (@(posedge clk) disable iff (sys_rst)
    conv_valid && clean == 2'h2 |-> gap == period) else $error("result spacing wrong");
  AST_READ_WORD: assert property (@(posedge clk) disable iff (sys_rst)
    sfr_rd && sfr_addr == 8'hd4 |=> sfr_rdata == word) else $error("word readback wrong");
  AST_CTRL_PINS: assert property (@(posedge clk) disable iff (sys_rst)
    sfr_wr && sfr_addr == 8'hd2 |=> {burnout_en, input_buffer_select, aux_use_ext_ref,
    main_use_ext_ref} == $past(ctl_lo)) else $error("control pins wrong");
  AST_BURNOUT: assert property (@(posedge clk) disable iff (sys_rst)
    burnout_en |-> input_buffer_select != 2'h0) else $error("burnout without buffer");
  AST_CLAMP: assert property (@(posedge clk) disable iff (sys_rst)
    conv_valid && !ref_pos_ok && !$past(ref_pos_ok, 8) |-> &conv_data)
    else $error("result not clamped");
  AST_HOLD_OFS: assert property (@(posedge clk) disable iff (sys_rst)
    !ref_pos_ok && !$past(ref_pos_ok, 8) |=> $stable(cal_offset)) else $error("offset moved");
  AST_HOLD_GAIN: assert property (@(posedge clk) disable iff (sys_rst)
    !ref_neg_ok && !$past(ref_neg_ok, 8) |=> $stable(cal_gain)) else $error("gain moved");
endmodule
bind sdd_core sdd_core_chk #(.MOD_DIV(MOD_DIV), .RES_W(RES_W), .CAL_W(CAL_W)) u_chk (
  .clk(clk),
  .sys_rst(sys_rst),
  .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd),
  .ref_pos_ok(ref_pos_ok),
  .ref_neg_ok(ref_neg_ok),
  .step_change(step_change),
  .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata),
  .conv_valid(conv_valid),
  .main_use_ext_ref(main_use_ext_ref),
  .aux_use_ext_ref(aux_use_ext_ref),
  .burnout_en(burnout_en),
  .input_buffer_select(input_buffer_select),
  .conv_data(conv_data),
  .cal_offset(cal_offset),
  .cal_gain(cal_gain)
);

//--- tb_sigma_delta_decimation_control.sv
// Self-checking bench for the decimation control core.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin n_fail++; \
  $display("BAD %s exp %0h got %0h", nm, e, s); end end
module tb_sigma_delta_decimation_control;
  localparam int MD = 4;
  logic clk = 1'b0, sys_rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, step_change = 1'b0;
  logic ref_pos_ok = 1'b1, ref_neg_ok = 1'b1, ref2_ok = 1'b1;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, st, level = 8'h80;
  logic mod_bit, conv_valid, main_use_ext_ref, aux_use_ext_ref, burnout_en;
  logic [1:0] input_buffer_select;
  logic [23:0] conv_data, cal_offset, cal_gain, ofs0, gain0;
  int n_fail = 0, n_compared = 0, cyc = 0, since = 0, g;
  sdd_mod_model #(.DIV(MD)) u_mod (.clk(clk), .level(level), .mod_bit(mod_bit));
  sdd_core #(.MOD_DIV(MD)) uut (
    .clk(clk),
    .sys_rst(sys_rst),
    .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata),
    .mod_bit(mod_bit),
    .ref_pos_ok(ref_pos_ok),
    .ref_neg_ok(ref_neg_ok),
    .ref2_ok(ref2_ok),
    .step_change(step_change),
    .conv_data(conv_data),
    .conv_valid(conv_valid),
    .cal_offset(cal_offset),
    .cal_gain(cal_gain),
    .main_use_ext_ref(main_use_ext_ref),
    .aux_use_ext_ref(aux_use_ext_ref),
    .burnout_en(burnout_en),
    .input_buffer_select(input_buffer_select)
  );
  // Clock, cycles since the last result, and the hang limit.
  always #5 clk = ~clk;
  always @(posedge clk) begin
    since <= conv_valid ? 1 : since + 1;
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 d = sfr_rdata;
  endtask
  // Waits for the next result and returns its spacing from the one before.
  task automatic wv(output int gp);
    do begin
      @(posedge clk);
      #1;
    end while (conv_valid !== 1'b1);
    gp = since;
  endtask
  task automatic t_regs;
    rd(8'hd4, st);
    `CHK("word", 8'h45, st)
    rd(8'hd1, st);
    `CHK("mode", 8'h00, st)
    rd(8'h00, st);
    `CHK("unmapped", 8'h00, st)
  endtask
  task automatic t_ctrl;
    wr(8'hd2, 8'h10);
    @(posedge clk);
    `CHK("burnout", 1'b0, burnout_en)
    wr(8'hd2, 8'h1f);
    @(posedge clk);
    `CHK("pins", 5'h1f, {burnout_en, input_buffer_select, aux_use_ext_ref, main_use_ext_ref})
    wr(8'hd2, 8'h00);
  endtask
  // Word limits with chop off, the chop clamp and the notch with a legal word.
  task automatic t_rate;
    logic [7:0] w[4] = '{8'h03, 8'h03, 8'h44, 8'hff};
    logic [7:0] m[4] = '{8'h08, 8'h00, 8'h48, 8'h08};
    for (int i = 0; i < 4; i++) begin
      wr(8'hd4, w[i]);
      wr(8'hd1, m[i]);
      repeat (3) wv(g);
      `CHK("period", MD * 8 * ((!m[i][3] && w[i] < 13) ? 13 : w[i]) * (m[i][3] ? 1 : 3), g)
    end
  endtask
  task automatic t_switch;
    wr(8'hd4, 8'h03);
    repeat (2) wv(g);
    repeat (20) @(posedge clk);
    wr(8'hd4, 8'h06);
    wv(g);
    `CHK("old period", MD * 24, g)
    wv(g);
    `CHK("new period", MD * 48, g)
    wr(8'hd4, 8'h03);
    repeat (2) wv(g);
  endtask
  task automatic t_step;
    @(posedge clk);
    step_change <= 1'b1;
    @(posedge clk);
    step_change <= 1'b0;
    wv(g);
    `CHK("settle", MD * 72, g)
  endtask
  // Offset then gain calibration with a good reference and the longest word.
  task automatic t_cal;
    wr(8'hd4, 8'hff);
    wv(g);
    for (int i = 0; i < 2; i++) begin
      wr(8'hd2, i[0] ? 8'h40 : 8'h20);
      repeat (400) @(posedge clk);
      rd(8'hd8, st);
      `CHK("cal busy", 8'h40, st & 8'h5c)
      repeat (8000) @(posedge clk);
      rd(8'hd8, st);
      `CHK("cal done", 8'h00, st & 8'h5c)
    end
    `CHK("cal upd", 1'b1, cal_offset != 24'h000000 && cal_gain != 24'h000000)
  endtask
  // Reference loss on either primary pin before a calibration, then the secondary pair.
  task automatic t_ref;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      ref_pos_ok <= i[0];
      ref_neg_ok <= !i[0];
      repeat (2) wv(g);
      `CHK("clamp", 1'b1, &conv_data)
      ofs0 = cal_offset;
      gain0 = cal_gain;
      wr(8'hd2, i[0] ? 8'h40 : 8'h20);
      repeat (400) @(posedge clk);
      rd(8'hd8, st);
      `CHK("status", i[0] ? 8'h14 : 8'h18, st & 8'h5c)
      `CHK("cal regs", {ofs0, gain0}, {cal_offset, cal_gain})
    end
    @(posedge clk);
    ref_pos_ok <= 1'b1;
    ref_neg_ok <= 1'b1;
    ref2_ok <= 1'b0;
    repeat (2) wv(g);
    rd(8'hd8, st);
    `CHK("flags", 8'h00, st & 8'h1c)
    `CHK("unclamped", 1'b0, &conv_data)
  endtask
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_ctrl();
    t_rate();
    t_switch();
    t_step();
    t_ref();
    t_cal();
    end_sim();
  end
endmodule
